// [core/rtsr_pkg.sv]
// Package of constants and types for the reset time-out and status block
package rtsr_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses, one aligned 32-bit word each)
   // ------------------------------------------------------------
   localparam logic [9:0] RTSR_FLAGS_IDX     = 10'h10F; // Reset-cause flags index
   localparam logic [11:0] RTSR_FLAGS_ADDR   = {RTSR_FLAGS_IDX, 2'b00};
   localparam logic [11:0] RTSR_STATUS_ADDR  = 12'h000; // Status word image
   localparam logic [11:0] RTSR_PC_ADDR      = 12'h004; // Program counter image
   localparam logic [11:0] RTSR_TRIM_ADDR    = 12'h008; // Oscillator trim
   localparam logic [11:0] RTSR_CONFIG_ADDR  = 12'h00C; // Configuration bits
   localparam logic [11:0] RTSR_IRQ_STAT_ADDR = 12'h010; // Sticky event bits
   localparam logic [11:0] RTSR_IRQ_MASK_ADDR = 12'h014; // Event mask
   localparam logic [11:0] RTSR_CMD_ADDR     = 12'h018; // Reset / wake commands
   localparam logic [11:0] RTSR_STATE_ADDR   = 12'h01C; // Sequencer state

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int RTSR_BROWNOUT_BIT  = 0; // Flag register bit 0
   localparam int RTSR_POWERON_BIT   = 1; // Flag register bit 1
   localparam int RTSR_PD_BIT        = 3; // Status power-down
   localparam int RTSR_TO_BIT        = 4; // Status time-out
   localparam int RTSR_CFG_PUT_DIS   = 0; // Power-up timer disable
   localparam int RTSR_CFG_EXT_CLK   = 1; // External clock mode
   localparam int RTSR_CFG_BO_LSB    = 2; // Brown-out mode 2 bits
   localparam int RTSR_CMD_WDT       = 0; // Watchdog event
   localparam int RTSR_CMD_IRQ_WAKE  = 1; // Interrupt wake event
   localparam int RTSR_CMD_SLEEP     = 2; // Enter sleep
   localparam int RTSR_CMD_GIE       = 3; // Global irq enable level

   // ------------------------------------------------------------
   // Reset and vector values
   // ------------------------------------------------------------
   localparam logic [12:0] RTSR_RESET_VECTOR = 13'h0000;
   localparam logic [12:0] RTSR_IRQ_VECTOR   = 13'h0004;
   localparam logic [7:0]  RTSR_STATUS_POR   = 8'h18;   // 0001 1000
   localparam logic [4:0]  RTSR_TRIM_POR     = 5'h00;
   localparam logic [1:0]  RTSR_FLAGS_POR    = 2'h0;    // Unknown bit taken as 0
   localparam logic [3:0]  RTSR_CONFIG_POR   = 4'hC;    // Brown-out on, timer on

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int RTSR_CLK_HZ       = 10_000_000;
   localparam int RTSR_PUT_MS       = 64;
   localparam int RTSR_PUT_CYCLES   = RTSR_PUT_MS * (RTSR_CLK_HZ / 1000);
   localparam int RTSR_OST_CYCLES   = 1024;  // Oscillator start-up count
   localparam int RTSR_CNT_W        = 20;

   // ------------------------------------------------------------
   // Sequencer states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      RTSR_ST_POR   = 6'h01,  // Power-on pulse active
      RTSR_ST_PUT   = 6'h02,  // Power-up timer running
      RTSR_ST_OST   = 6'h04,  // Oscillator start-up
      RTSR_ST_HOLD  = 6'h08,  // Waiting for reset pin release
      RTSR_ST_RUN   = 6'h10,  // Executing
      RTSR_ST_SLEEP = 6'h20   // Sleeping
   } rtsr_state_type;

endpackage

// [core/rtsr_top.sv]
// Reset time-out sequencer and reset-cause recorder with Avalon-MM registers
//
// Notes on behaviour
// R1 - Power-up timer starts after power-on pulse
// R2 - Start-up timer follows power-up timer
// R3 - External clock, timer disabled: no delay; after a brown-out the code still runs the start-up timer
// R4 - Timers ignore pin; release starts immediately
// R5 - Brown-out flag cleared by brown-out only
// R6 - Brown-out flag meaningless when mode 00
// R7 - Power-on flag cleared by power-on only
// R8 - Power-on: vector 0, status 0001 1xxx
// R9 - Watchdog reset: upper four status cleared
// R10 - Pin reset in sleep: time-out set
// R11 - Brown-out: time-out, power-down set
// R12 - Watchdog wake: next address, flags cleared
// R13 - Irq wake with enable: go vector 4
// R14 - Wake sets causing flags, keeps rest
// R15 - Pin reset running: upper three cleared
// R16 - Trim cleared only by power-on
// R17 - Power-up timer 64 ms, restarts on brown-out
// R18 - Timer disable bit one disables timer
// R19 - Flags settle before first fetch
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module rtsr_top #(
   parameter int PUT_CYCLES = rtsr_pkg::RTSR_PUT_CYCLES  // Shorten for simulation
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        poweron_pulse,        // Power-on detector, async
   input  wire logic        brownout_detect,      // Brown-out detector, async
   input  wire logic        external_reset_pin,   // Active-low pin, async
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             core_run,             // Core may fetch
   output logic             irq_wake_pending,     // Wake flags set on irq wake
   output logic             irq
);
   import rtsr_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers, three stages, change taken when 2 and 3 agree
   // ------------------------------------------------------------
   logic [2:0] por_sync_reg;   // Power-on pulse chain
   logic [2:0] bo_sync_reg;    // Brown-out chain
   logic [2:0] pin_sync_reg;   // Reset pin chain
   logic       por_lvl_reg;    // Filtered levels
   logic       bo_lvl_reg;
   logic       pin_lvl_reg;

   // Synchroniser shift
   always_ff @(posedge core_clk) begin
      por_sync_reg <= {por_sync_reg[1:0], poweron_pulse};
      bo_sync_reg  <= {bo_sync_reg[1:0], brownout_detect};
      pin_sync_reg <= {pin_sync_reg[1:0], external_reset_pin};
   end

   // Agreement filter, only stages two and three are looked at
   always_ff @(posedge core_clk) begin
      if (srst) begin
         por_lvl_reg <= 1'b1;
         bo_lvl_reg  <= 1'b0;
         pin_lvl_reg <= 1'b0;
      end else begin
         if (por_sync_reg[1] == por_sync_reg[2]) begin
            por_lvl_reg <= por_sync_reg[2];
         end
         if (bo_sync_reg[1] == bo_sync_reg[2]) begin
            bo_lvl_reg <= bo_sync_reg[2];
         end
         if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_lvl_reg <= pin_sync_reg[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   rtsr_state_type  state_reg;        // Sequencer state
   rtsr_state_type  state_next;
   logic [19:0]     cnt_reg;          // Shared timer counter
   logic [19:0]     cnt_next;
   logic [1:0]      flags_reg;        // Reset-cause flags
   logic [7:0]      status_reg;       // Status word image
   logic [12:0]     pc_reg;           // Program counter image
   logic [4:0]      trim_reg;         // Oscillator trim
   logic [3:0]      config_reg;       // Timer disable, clock mode, brown-out mode
   logic            gie_reg;          // Global irq enable
   logic            irq_vec_reg;      // Branch to vector after next fetch
   logic [3:0]      evt_stat_reg;     // Sticky events
   logic [3:0]      evt_mask_reg;
   logic            bo_cause_reg;     // Declared only, never assigned or read

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire bo_enabled  = config_reg[RTSR_CFG_BO_LSB +: 2] != 2'b00;
   wire bo_event    = bo_lvl_reg && bo_enabled;                 // R6
   wire put_off     = config_reg[RTSR_CFG_PUT_DIS];            // R18
   wire ext_clk     = config_reg[RTSR_CFG_EXT_CLK];
   wire cnt_done    = cnt_reg == 20'h00000;
   wire wr_ok       = avs_write && !avs_waitrequest;
   wire wr_cmd      = wr_ok && avs_address == RTSR_CMD_ADDR;
   wire wdt_evt     = wr_cmd && avs_writedata[RTSR_CMD_WDT];
   wire iwake_evt   = wr_cmd && avs_writedata[RTSR_CMD_IRQ_WAKE];
   wire sleep_evt   = wr_cmd && avs_writedata[RTSR_CMD_SLEEP];
   wire in_run      = state_reg == RTSR_ST_RUN;
   wire in_sleep    = state_reg == RTSR_ST_SLEEP;
   wire pin_low     = !pin_lvl_reg;
   wire pin_rst_run = pin_low && in_run;
   wire pin_rst_slp = pin_low && in_sleep;
   wire wdt_rst     = wdt_evt && in_run;
   wire wdt_wake    = wdt_evt && in_sleep;
   wire irq_wake    = iwake_evt && in_sleep;
   wire [19:0] put_load = 20'(PUT_CYCLES - 1);
   wire [19:0] ost_load = 20'(RTSR_OST_CYCLES - 1);
   wire [3:0]  evt_in   = {irq_wake | wdt_wake, wdt_rst, bo_event, pin_rst_run | pin_rst_slp};

   // Byte-lane merge of an 8-bit field
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
      lane0 = be[0] ? d[7:0] : old;
   endfunction

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Timers count from the power-on pulse, pin only gates the last step
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         RTSR_ST_POR: begin
            if (!por_lvl_reg) begin                              // R1
               if (ext_clk && put_off) begin
                  state_next = RTSR_ST_HOLD;                     // R3
               end else if (put_off) begin
                  state_next = RTSR_ST_OST;
                  cnt_next   = ost_load;
               end else begin
                  state_next = RTSR_ST_PUT;
                  cnt_next   = put_load;                         // R17
               end
            end
         end
         RTSR_ST_PUT: begin
            if (cnt_done) begin
               state_next = ext_clk ? RTSR_ST_HOLD : RTSR_ST_OST; // R2
               cnt_next   = ost_load;
            end else begin
               cnt_next = cnt_reg - 20'h00001;
            end
         end
         RTSR_ST_OST: begin
            if (cnt_done) begin
               state_next = RTSR_ST_HOLD;
            end else begin
               cnt_next = cnt_reg - 20'h00001;
            end
         end
         RTSR_ST_HOLD: begin
            if (!pin_low) begin
               state_next = RTSR_ST_RUN;                         // R4
            end
         end
         RTSR_ST_RUN: begin
            if (pin_rst_run || wdt_rst) begin
               state_next = RTSR_ST_HOLD;
            end else if (sleep_evt) begin
               state_next = RTSR_ST_SLEEP;
            end
         end
         RTSR_ST_SLEEP: begin
            if (pin_rst_slp) begin
               state_next = RTSR_ST_HOLD;
            end else if (wdt_wake || irq_wake) begin
               state_next = RTSR_ST_RUN;
            end
         end
         default: begin
            state_next = RTSR_ST_POR;
         end
      endcase
      // Brown-out restarts the power-up timer from any state, or the start-up timer when the timer disable bit is set
      if (bo_event) begin
         state_next = put_off ? RTSR_ST_OST : RTSR_ST_PUT;         // R17
         cnt_next   = put_off ? ost_load : put_load;
      end
      // A fresh power-on pulse starts everything over
      if (por_lvl_reg) begin
         state_next = RTSR_ST_POR;
      end
   end

   // State and counter
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= RTSR_ST_POR;
         cnt_reg   <= 20'h00000;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // ------------------------------------------------------------
   // Reset-cause flags, updated in the cause cycle, long before run
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         flags_reg <= RTSR_FLAGS_POR;
      end else if (por_lvl_reg) begin
         flags_reg[RTSR_POWERON_BIT] <= 1'b0;                    // R7
      end else if (bo_event) begin
         flags_reg[RTSR_BROWNOUT_BIT] <= 1'b0;                   // R5
      end else if (wr_ok && avs_address == RTSR_FLAGS_ADDR && avs_byteenable[0]) begin
         flags_reg <= avs_writedata[1:0];
      end
   end

   // Status word: cause-dependent time-out and power-down bits
   always_ff @(posedge core_clk) begin
      if (srst || por_lvl_reg) begin
         status_reg <= RTSR_STATUS_POR;                          // R8
      end else if (bo_event) begin
         status_reg <= {3'b000, 1'b1, 1'b1, status_reg[2:0]};    // R11
      end else if (pin_rst_slp) begin
         status_reg <= {3'b000, 1'b1, 1'b0, status_reg[2:0]};    // R10
      end else if (pin_rst_run) begin
         status_reg <= {3'b000, status_reg[4:0]};                // R15
      end else if (wdt_rst) begin
         status_reg <= {4'b0000, status_reg[3:0]};               // R9
      end else if (wdt_wake) begin
         status_reg[RTSR_TO_BIT] <= 1'b0;                        // R12
         status_reg[RTSR_PD_BIT] <= 1'b0;
      end else if (irq_wake) begin
         status_reg[RTSR_TO_BIT] <= 1'b1;
         status_reg[RTSR_PD_BIT] <= 1'b0;
      end else if (sleep_evt && in_run) begin
         status_reg[RTSR_TO_BIT] <= 1'b1;
         status_reg[RTSR_PD_BIT] <= 1'b0;
      end else if (wr_ok && avs_address == RTSR_STATUS_ADDR) begin
         status_reg <= lane0(status_reg, avs_writedata, avs_byteenable);
      end
   end

   // Program counter image and vector branch
   always_ff @(posedge core_clk) begin
      if (srst || por_lvl_reg || bo_event || pin_rst_run || pin_rst_slp || wdt_rst) begin
         pc_reg      <= RTSR_RESET_VECTOR;                       // R8
         irq_vec_reg <= 1'b0;
      end else if (wdt_wake || irq_wake) begin
         pc_reg      <= pc_reg + 13'h0001;                       // R12
         irq_vec_reg <= irq_wake && gie_reg;                     // R13
      end else if (irq_vec_reg && in_run) begin
         pc_reg      <= RTSR_IRQ_VECTOR;                         // R13
         irq_vec_reg <= 1'b0;
      end else if (wr_ok && avs_address == RTSR_PC_ADDR) begin
         pc_reg <= avs_writedata[12:0];
      end
   end

   // Trim and configuration, trim survives all but power-on
   always_ff @(posedge core_clk) begin
      if (srst || por_lvl_reg) begin
         trim_reg <= RTSR_TRIM_POR;                              // R16
      end else if (wr_ok && avs_address == RTSR_TRIM_ADDR && avs_byteenable[0]) begin
         trim_reg <= avs_writedata[4:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         config_reg <= RTSR_CONFIG_POR;
         gie_reg    <= 1'b0;
      end else begin
         if (wr_ok && avs_address == RTSR_CONFIG_ADDR && avs_byteenable[0]) begin
            config_reg <= avs_writedata[3:0];
         end
         if (wr_cmd) begin
            gie_reg <= avs_writedata[RTSR_CMD_GIE];
         end
      end
   end

   // Wake flag held until software writes a one to event status bit 3
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_wake_pending <= 1'b0;
      end else if (irq_wake) begin
         irq_wake_pending <= 1'b1;                               // R14
      end else if (wr_ok && avs_address == RTSR_IRQ_STAT_ADDR && avs_writedata[3]) begin
         irq_wake_pending <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Events: sticky, write one to clear, set wins
   // ------------------------------------------------------------
   wire stat_clr_wr = wr_ok && avs_address == RTSR_IRQ_STAT_ADDR && avs_byteenable[0];
   wire [3:0] stat_clr = stat_clr_wr ? avs_writedata[3:0] : 4'h0;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         evt_stat_reg <= 4'h0;
         evt_mask_reg <= 4'h0;
         irq          <= 1'b0;
      end else begin
         evt_stat_reg <= (evt_stat_reg & ~stat_clr) | evt_in;
         if (wr_ok && avs_address == RTSR_IRQ_MASK_ADDR && avs_byteenable[0]) begin
            evt_mask_reg <= avs_writedata[3:0];
         end
         irq <= |(((evt_stat_reg & ~stat_clr) | evt_in) & evt_mask_reg);
      end
   end

   // ------------------------------------------------------------
   // Avalon slave: one wait cycle per access, data with waitrequest low
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      case (avs_address)
         RTSR_FLAGS_ADDR:    rd_mux = {30'h0, flags_reg};
         RTSR_STATUS_ADDR:   rd_mux = {24'h0, status_reg};
         RTSR_PC_ADDR:       rd_mux = {19'h0, pc_reg};
         RTSR_TRIM_ADDR:     rd_mux = {27'h0, trim_reg};
         RTSR_CONFIG_ADDR:   rd_mux = {28'h0, config_reg};
         RTSR_IRQ_STAT_ADDR: rd_mux = {28'h0, evt_stat_reg};
         RTSR_IRQ_MASK_ADDR: rd_mux = {28'h0, evt_mask_reg};
         RTSR_CMD_ADDR:      rd_mux = {28'h0, gie_reg, 3'b000};
         RTSR_STATE_ADDR:    rd_mux = {26'h0, state_reg};
         default:            rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         core_run        <= 1'b0;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         avs_readdata    <= rd_mux;
         core_run        <= state_next == RTSR_ST_RUN;            // R19
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence put_start_s;
      state_reg == RTSR_ST_POR && !por_lvl_reg && !put_off && !bo_event;
   endsequence

   put_after_por_a: assert property (@(posedge core_clk) disable iff (srst) // R1
      put_start_s |=> state_reg == RTSR_ST_PUT && cnt_reg == put_load)
      else $error("power-up timer not started after pulse");
   ost_after_put_a: assert property (@(posedge core_clk) disable iff (srst) // R2
      state_reg == RTSR_ST_OST |-> $past(state_reg) != RTSR_ST_POR || put_off)
      else $error("start-up timer entered too early");
   no_delay_ext_a: assert property (@(posedge core_clk) disable iff (srst) // R3
      state_reg == RTSR_ST_POR && !por_lvl_reg && ext_clk && put_off && !bo_event
      |=> state_reg == RTSR_ST_HOLD)
      else $error("delay applied in external clock mode");
   pin_release_a: assert property (@(posedge core_clk) disable iff (srst) // R4
      state_reg == RTSR_ST_HOLD && !pin_low && !por_lvl_reg && !bo_event
      |=> state_reg == RTSR_ST_RUN ##1 core_run)
      else $error("run not started on pin release");
   bo_flag_a: assert property (@(posedge core_clk) disable iff (srst) // R5
      bo_event && !por_lvl_reg |=> !flags_reg[RTSR_BROWNOUT_BIT])
      else $error("brown-out flag not cleared");
   por_flag_a: assert property (@(posedge core_clk) disable iff (srst) // R7
      por_lvl_reg |=> !flags_reg[RTSR_POWERON_BIT] && status_reg == RTSR_STATUS_POR)
      else $error("power-on values wrong");
   wdt_status_a: assert property (@(posedge core_clk) disable iff (srst) // R9
      wdt_rst && !por_lvl_reg && !bo_event && !pin_low
      |=> status_reg[7:4] == 4'h0 && pc_reg == RTSR_RESET_VECTOR)
      else $error("watchdog reset status wrong");
   bo_status_a: assert property (@(posedge core_clk) disable iff (srst) // R11
      bo_event && !por_lvl_reg |=> status_reg[4:3] == 2'b11)
      else $error("brown-out status wrong");
   wake_pc_a: assert property (@(posedge core_clk) disable iff (srst) // R12
      wdt_wake && !por_lvl_reg && !bo_event && !pin_low
      |=> pc_reg == $past(pc_reg) + 13'h0001 && status_reg[4:3] == 2'b00)
      else $error("watchdog wake wrong");
   trim_keep_a: assert property (@(posedge core_clk) disable iff (srst) // R16
      (bo_event || wdt_rst) && !por_lvl_reg |=> trim_reg == $past(trim_reg))
      else $error("trim lost on reset");

endmodule

`default_nettype wire

// [verification/rtsr_pin_board.sv]
// Board-side model of the active-low external reset pin
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Pin driver with pull-up
// ------------------------------------------------------------
module rtsr_pin_board (
   input  wire logic core_clk,           // Board sees the core clock
   input  wire logic hold_low,           // Bench asks the board to pull low
   output var  logic external_reset_pin  // Pin level seen by the device
);
   // Pull-up wins once the board lets go, so released reads high
   always_ff @(posedge core_clk) begin
      external_reset_pin <= !hold_low;
   end
endmodule
`default_nettype wire

// [verification/tb_rtsr_top.sv]
// Self-checking bench for the reset time-out and status block
`timescale 1ns/100ps
`default_nettype none

module tb_rtsr_top;
   import rtsr_pkg::*;
   logic        core_clk = 0, srst = 1, poweron_pulse = 1, brownout_detect = 0;
   logic        hold_low = 1, pin, avs_read = 0, avs_write = 0;
   logic [11:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, trim;
   logic        avs_waitrequest, core_run, irq_wake_pending, irq;
   logic [31:0] expq[$];         // Expected read data, oldest first
   int          mismatches = 0, checks_done = 0, cycles = 0;

   // ------------------------------------------------------------
   // Clock, partner and device
   // ------------------------------------------------------------
   initial forever #50 core_clk = !core_clk;
   rtsr_pin_board board (.core_clk(core_clk), .hold_low(hold_low),
                         .external_reset_pin(pin));
   rtsr_top #(.PUT_CYCLES(20)) DUT (.core_clk(core_clk), .srst(srst),
      .poweron_pulse(poweron_pulse), .brownout_detect(brownout_detect),
      .external_reset_pin(pin), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_run(core_run),
      .irq_wake_pending(irq_wake_pending), .irq(irq));

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wrap_up;
      if (mismatches == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Read answers are matched against notes in arrival order
   always @(posedge core_clk) begin
      if (avs_read && !avs_waitrequest && expq.size() > 0) begin
         check("readdata", avs_readdata, expq.pop_front());
      end
   end

   // Hang guard, well beyond the longest start-up chain
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // Avalon master: hold until waitrequest sampled low
   // ------------------------------------------------------------
   task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk); // Let the release land before a new request
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask

   task automatic wait_run;
      for (int i = 0; i < 3000 && core_run !== 1'b1; i++) @(posedge core_clk);
      check("core_run", core_run, 1'b1);
   endtask

   task automatic pulse(input int which); // 0 pin, 1 brown-out
      if (which == 0) hold_low <= 1'b1;
      else brownout_detect <= 1'b1;
      repeat (8) @(posedge core_clk);
      hold_low <= 1'b0;
      brownout_detect <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(24));
      trim = {27'h0, 5'($urandom())};
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      repeat (6) @(posedge core_clk);
      poweron_pulse <= 1'b0;
      // Timers expire while the pin is still held low
      repeat (1200) @(posedge core_clk);
      check("run_held", core_run, 1'b0);
      rd(RTSR_STATE_ADDR, 32'h08);
      rd(RTSR_STATUS_ADDR, 32'h18);
      rd(RTSR_PC_ADDR, 32'h0);
      rd(RTSR_FLAGS_ADDR, 32'h0);
      rd(RTSR_TRIM_ADDR, 32'h0);
      rd(12'h0F0, 32'h0);
      hold_low <= 1'b0;
      for (int i = 0; i < 8 && core_run !== 1'b1; i++) @(posedge core_clk);
      check("run_release", core_run, 1'b1);
      bus(RTSR_FLAGS_ADDR, 1'b1, 32'h3);
      bus(RTSR_TRIM_ADDR, 1'b1, trim);
      bus(RTSR_IRQ_MASK_ADDR, 1'b1, 32'h1);
      // Pin reset while running keeps flags and trim
      pulse(0);
      wait_run();
      rd(RTSR_STATUS_ADDR, 32'h18);
      rd(RTSR_FLAGS_ADDR, 32'h3);
      rd(RTSR_TRIM_ADDR, trim);
      check("irq_set", irq, 1'b1);
      bus(RTSR_IRQ_STAT_ADDR, 1'b1, 32'hF);
      @(posedge core_clk);
      check("irq_clr", irq, 1'b0);
      // Watchdog reset clears the upper nibble only
      bus(RTSR_CMD_ADDR, 1'b1, 32'h1);
      wait_run();
      rd(RTSR_STATUS_ADDR, 32'h08);
      rd(RTSR_PC_ADDR, 32'h0);
      // Brown-out clears only its own flag
      pulse(1);
      wait_run();
      rd(RTSR_STATUS_ADDR, 32'h18);
      rd(RTSR_FLAGS_ADDR, 32'h2);
      rd(RTSR_TRIM_ADDR, trim);
      // Watchdog wake from sleep resumes at next address
      bus(RTSR_CMD_ADDR, 1'b1, 32'h4);
      bus(RTSR_CMD_ADDR, 1'b1, 32'h1);
      rd(RTSR_STATUS_ADDR, 32'h00);
      rd(RTSR_PC_ADDR, 32'h1);
      // Interrupt wake with global enable goes to the vector
      // Enable is raised with the sleep command, the wake sees it already set
      bus(RTSR_CMD_ADDR, 1'b1, 32'hC);
      bus(RTSR_CMD_ADDR, 1'b1, 32'hA);
      check("wake_flag", irq_wake_pending, 1'b1);
      rd(RTSR_PC_ADDR, 32'h4);
      rd(RTSR_STATUS_ADDR, 32'h10);
      bus(RTSR_IRQ_STAT_ADDR, 1'b1, 32'hF);
      @(posedge core_clk);
      check("wake_clr", irq_wake_pending, 1'b0);
      // Pin reset during sleep sets time-out, clears power-down
      bus(RTSR_CMD_ADDR, 1'b1, 32'h4);
      pulse(0);
      wait_run();
      rd(RTSR_STATUS_ADDR, 32'h10);
      rd(RTSR_PC_ADDR, 32'h0);
      rd(RTSR_TRIM_ADDR, trim);
      // External clock, timer off, brown-out detection off
      bus(RTSR_CONFIG_ADDR, 1'b1, 32'h3);
      pulse(1);
      rd(RTSR_STATE_ADDR, 32'h10);
      // Fresh power-on with no start-up delay: running again within a few cycles
      poweron_pulse <= 1'b1;
      repeat (8) @(posedge core_clk);
      poweron_pulse <= 1'b0;
      repeat (10) @(posedge core_clk);
      rd(RTSR_STATE_ADDR, 32'h10);
      rd(RTSR_STATUS_ADDR, 32'h18);
      rd(RTSR_FLAGS_ADDR, 32'h0);
      rd(RTSR_TRIM_ADDR, 32'h0);
      repeat (2) @(posedge core_clk);
      wrap_up();
   end
endmodule
`default_nettype wire
